// ### shared/urwf_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the receiver block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: receive sampling runs from a 16x baud strobe supplied by the baud generator
`ifndef URWF_PARAMS_SVH
`define URWF_PARAMS_SVH

`define URWF_OFS_CTRL_ONE 8'h00
`define URWF_OFS_CTRL_TWO 8'h04
`define URWF_OFS_STATUS_ONE 8'h08
`define URWF_OFS_CTRL_THREE 8'h0C
`define URWF_OFS_DATA 8'h10

// control one
`define URWF_C1_NINE_BIT 4
`define URWF_C1_WAKE_ADDR 3
`define URWF_C1_IDLE_TYPE 2
`define URWF_C1_PARITY_EN 1
`define URWF_C1_PARITY_ODD 0
// control two
`define URWF_C2_TX_EMPTY_IE 7
`define URWF_C2_TX_DONE_IE 6
`define URWF_C2_RX_FULL_IE 5
`define URWF_C2_IDLE_IE 4
`define URWF_C2_RX_EN 2
`define URWF_C2_SLEEP 1
// control three
`define URWF_C3_RX_NINTH 7
`define URWF_C3_TX_NINTH 6
`define URWF_C3_OVERRUN_IE 3
`define URWF_C3_NOISE_IE 2
`define URWF_C3_FRAME_IE 1
`define URWF_C3_PARITY_IE 0
// status one
`define URWF_S1_TX_EMPTY 7
`define URWF_S1_TX_DONE 6
`define URWF_S1_RX_FULL 5
`define URWF_S1_IDLE 4
`define URWF_S1_OVERRUN 3
`define URWF_S1_NOISE 2
`define URWF_S1_FRAME 1
`define URWF_S1_PARITY 0

`define URWF_CTRL_RESET 8'h00
`define URWF_OVERSAMPLE 16
`define URWF_FRAME_BITS8 10
`define URWF_FRAME_BITS9 11

`endif

// ### shared/urwf_pkg.sv
// Purpose: types shared by the receiver block
// Assumes: nothing
// Notes: state codes left to the tool
package urwf_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urwf_rx_state_t;
endpackage

// ### verilog/urwf_core.sv
// Purpose: serial receiver with wakeup, status flags, interrupt grouping, AHB-Lite registers
// Assumes: rt_tick pulses one cycle at 16x baud; transmitter shifter sits outside
// Notes: zero-wait AHB slave, always OKAY
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "urwf_params.svh"

module urwf_core (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial line and baud strobe
  input wire logic receive_line,
  input wire logic rt_tick,
  // transmitter hookup
  input wire logic transmit_buffer_empty_flag,
  input wire logic transmit_complete_flag,
  output logic [7:0] tx_data,
  output logic tx_write,
  output logic transmit_ninth_bit,
  // interrupt requests
  output logic irq_tx,
  output logic irq_rx,
  output logic irq_err
);
  urwf_pkg::urwf_rx_state_t state;
  logic [7:0] serial_control_one, serial_control_two, serial_control_three;
  logic [7:0] serial_data_register;
  logic receive_ninth_bit;
  logic receive_full_flag, idle_flag, overrun_flag, noise_flag, framing_error_flag;
  logic parity_error_flag;
  logic [2:0] hist;
  logic [4:0] slot, cs;
  logic [3:0] bitn;
  logic [1:0] lows;
  logic s8, s9, frame_noise;
  logic [8:0] rx_bits;
  logic comp, comp_nf, comp_fe, comp_pf;
  logic [8:0] comp_data;
  logic [7:0] idle_cnt, idle_thr;
  logic idle_hit, idle_armed, mark_hit;
  logic [4:0] arm;
  logic acc, wr_q, data_rd, stat_rd;
  logic [7:0] addr_q;

  wire nine = serial_control_one[`URWF_C1_NINE_BIT];
  wire wake_addr = serial_control_one[`URWF_C1_WAKE_ADDR];
  wire receive_enable_bit = serial_control_two[`URWF_C2_RX_EN];
  wire receiver_sleep_bit = serial_control_two[`URWF_C2_SLEEP];
  wire idle_type_select = serial_control_one[`URWF_C1_IDLE_TYPE];
  wire [3:0] last_bit = nine ? 4'h8 : 4'h7;
  wire edge_seen = rt_tick && receive_enable_bit && (hist == 3'h7) && !receive_line;
  wire maj = (s8 & s9) | (s8 & receive_line) | (s9 & receive_line);
  wire disagree = (s8 != s9) || (s9 != receive_line);
  wire sw_ctrl_two = wr_q && (addr_q == `URWF_OFS_CTRL_TWO);

  assign cs = (slot == 5'(`URWF_OVERSAMPLE)) ? 5'h01 : slot + 5'h01;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign transmit_ninth_bit = serial_control_three[`URWF_C3_TX_NINTH];

  // ahb address phase; zero wait so every accepted phase completes next cycle
  assign acc = hsel && hready && htrans[1];
  assign data_rd = acc && !hwrite && (haddr == `URWF_OFS_DATA);
  assign stat_rd = acc && !hwrite && (haddr == `URWF_OFS_STATUS_ONE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= acc && hwrite;
      addr_q <= haddr;
    end
  end

  // read data registered at the address phase so it stands through the data phase
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      case (haddr)
        `URWF_OFS_CTRL_ONE: hrdata <= {24'h000000, serial_control_one};
        `URWF_OFS_CTRL_TWO: hrdata <= {24'h000000, serial_control_two};
        `URWF_OFS_CTRL_THREE: hrdata <= {24'h000000, receive_ninth_bit, serial_control_three[6:0]};
        `URWF_OFS_STATUS_ONE: hrdata <= {24'h000000, transmit_buffer_empty_flag,
          transmit_complete_flag, receive_full_flag, idle_flag, overrun_flag, noise_flag,
          framing_error_flag, parity_error_flag};
        `URWF_OFS_DATA: hrdata <= {24'h000000, serial_data_register};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // control registers; hardware wakeup clears sleep unless software writes control two the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      serial_control_one <= `URWF_CTRL_RESET;
      serial_control_two <= `URWF_CTRL_RESET;
      serial_control_three <= `URWF_CTRL_RESET;
    end else begin
      if (wr_q && addr_q == `URWF_OFS_CTRL_ONE) begin
        serial_control_one <= {3'h0, hwdata[4:0]};
      end
      if (wr_q && addr_q == `URWF_OFS_CTRL_THREE) begin
        serial_control_three <= {1'b0, hwdata[6:0]};
      end
      if (sw_ctrl_two) begin
        serial_control_two <= {hwdata[7:4], 1'b0, hwdata[2:1], 1'b0};
      end else if ((idle_hit && !wake_addr) || mark_hit) begin
        serial_control_two[`URWF_C2_SLEEP] <= 1'b0;
      end
    end
  end

  // transmit buffer write goes straight to the outside transmitter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_data <= 8'h00;
      tx_write <= 1'b0;
    end else begin
      tx_write <= wr_q && (addr_q == `URWF_OFS_DATA);
      if (wr_q && addr_q == `URWF_OFS_DATA) begin
        tx_data <= hwdata[7:0];
      end
    end
  end

  // edge history; a framing error on a non-break frame refills it with highs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hist <= 3'h0;
    end else if (rt_tick) begin
      if (state == urwf_pkg::RX_STOP && cs == 5'd10 && !maj && rx_bits != 9'h000) begin
        hist <= 3'h7;
      end else begin
        hist <= {hist[1:0], receive_line};
      end
    end
  end

  // receive sequencer; edges realign the slot count, bits advance at slot 10
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= urwf_pkg::RX_IDLE;
      slot <= 5'h01;
      bitn <= 4'h0;
      lows <= 2'h0;
      s8 <= 1'b1;
      s9 <= 1'b1;
      frame_noise <= 1'b0;
      rx_bits <= 9'h000;
    end else if (!receive_enable_bit) begin
      state <= urwf_pkg::RX_IDLE;
    end else if (rt_tick) begin
      slot <= edge_seen ? 5'h01 : cs;
      case (state)
        urwf_pkg::RX_IDLE: begin
          if (edge_seen) begin
            state <= urwf_pkg::RX_START;
            lows <= 2'h0;
            frame_noise <= 1'b0;
            rx_bits <= 9'h000;
          end
        end
        urwf_pkg::RX_START: begin
          if (cs == 5'd3 || cs == 5'd5) begin
            lows <= lows + {1'b0, !receive_line};
          end
          if (cs == 5'd7 && (lows + {1'b0, !receive_line}) < 2'h2) begin
            state <= urwf_pkg::RX_IDLE;
          end
          if (cs >= 5'd8 && cs <= 5'd10 && receive_line) begin
            frame_noise <= 1'b1;
          end
          if (cs == 5'd10) begin
            state <= urwf_pkg::RX_DATA;
            bitn <= 4'h0;
          end
        end
        urwf_pkg::RX_DATA, urwf_pkg::RX_STOP: begin
          if (cs == 5'd8) begin
            s8 <= receive_line;
          end
          if (cs == 5'd9) begin
            s9 <= receive_line;
          end
          if (cs == 5'd10) begin
            if (disagree) begin
              frame_noise <= 1'b1;
            end
            if (state == urwf_pkg::RX_DATA) begin
              rx_bits[bitn] <= maj;
              bitn <= bitn + 4'h1;
              if (bitn == last_bit) begin
                state <= urwf_pkg::RX_STOP;
              end
            end else begin
              state <= urwf_pkg::RX_IDLE;
            end
          end
        end
        default: state <= urwf_pkg::RX_IDLE;
      endcase
    end
  end

  // frame completion strobe with its error conditions
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      comp <= 1'b0;
      comp_nf <= 1'b0;
      comp_fe <= 1'b0;
      comp_pf <= 1'b0;
      comp_data <= 9'h000;
      mark_hit <= 1'b0;
    end else begin
      comp <= receive_enable_bit && rt_tick && state == urwf_pkg::RX_STOP && cs == 5'd10;
      // address mark seen on the last data bit, ahead of the stop bit
      mark_hit <= receive_enable_bit && rt_tick && state == urwf_pkg::RX_DATA && cs == 5'd10 &&
        bitn == last_bit && maj && wake_addr && receiver_sleep_bit;
      comp_nf <= frame_noise || disagree;
      comp_fe <= !maj;
      comp_pf <= serial_control_one[`URWF_C1_PARITY_EN] &&
        ((^(nine ? rx_bits : {1'b0, rx_bits[7:0]})) != serial_control_one[`URWF_C1_PARITY_ODD]);
      comp_data <= nine ? rx_bits : {1'b0, rx_bits[7:0]};
    end
  end

  // idle line counter in 16x ticks
  assign idle_thr = nine ? 8'(`URWF_FRAME_BITS9 * `URWF_OVERSAMPLE) :
    8'(`URWF_FRAME_BITS8 * `URWF_OVERSAMPLE);
  assign idle_hit = rt_tick && receive_line && idle_cnt == idle_thr - 8'h01;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 8'h00;
    end else if (rt_tick) begin
      if (!receive_enable_bit || !receive_line ||
          (idle_type_select && state != urwf_pkg::RX_IDLE)) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt < idle_thr) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  // receive buffer and flags; a set in the clearing cycle wins
  wire take = comp && !receiver_sleep_bit && !framing_error_flag && !receive_full_flag;
  wire lose = comp && !receiver_sleep_bit && !framing_error_flag && receive_full_flag;
  wire set_idle = idle_hit && !receiver_sleep_bit && idle_armed;
  wire [4:0] clr = data_rd ? arm : 5'h00;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arm <= 5'h00;
    end else if (stat_rd) begin
      arm <= {receive_full_flag, idle_flag, overrun_flag, noise_flag, framing_error_flag};
    end else if (data_rd) begin
      arm <= 5'h00;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      serial_data_register <= 8'h00;
      receive_ninth_bit <= 1'b0;
      receive_full_flag <= 1'b0;
      idle_flag <= 1'b0;
      idle_armed <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else begin
      if (take) begin
        serial_data_register <= comp_data[7:0];
        receive_ninth_bit <= comp_data[8];
        idle_armed <= 1'b1;
      end else if (set_idle) begin
        idle_armed <= 1'b0;
      end
      receive_full_flag <= take || (receive_full_flag && !clr[4]);
      idle_flag <= set_idle || (idle_flag && !clr[3]);
      overrun_flag <= lose || (overrun_flag && !clr[2]);
      noise_flag <= (take && comp_nf) || (noise_flag && !clr[1]);
      framing_error_flag <= (take && comp_fe) || (framing_error_flag && !clr[0]);
      // parity has no arm slot; it clears with receive-full, which it always sets with
      parity_error_flag <= (take && comp_pf) || (parity_error_flag && !clr[4]);
    end
  end

  // interrupt grouping, each source masked on its own
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_tx <= 1'b0;
      irq_rx <= 1'b0;
      irq_err <= 1'b0;
    end else begin
      irq_tx <= (transmit_buffer_empty_flag && serial_control_two[`URWF_C2_TX_EMPTY_IE]) ||
        (transmit_complete_flag && serial_control_two[`URWF_C2_TX_DONE_IE]);
      irq_rx <= (receive_full_flag && serial_control_two[`URWF_C2_RX_FULL_IE]) ||
        (idle_flag && serial_control_two[`URWF_C2_IDLE_IE]);
      irq_err <= (overrun_flag && serial_control_three[`URWF_C3_OVERRUN_IE]) ||
        (noise_flag && serial_control_three[`URWF_C3_NOISE_IE]) ||
        (framing_error_flag && serial_control_three[`URWF_C3_FRAME_IE]) ||
        (parity_error_flag && serial_control_three[`URWF_C3_PARITY_IE]);
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_take;
    take |=> receive_full_flag && serial_data_register == $past(comp_data[7:0]);
  endproperty
  a_take: assert property (p_take) else $error("character not moved to buffer");

  property p_overrun;
    lose |=> overrun_flag && $stable(serial_data_register);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun mishandled");

  property p_edge;
    state == urwf_pkg::RX_IDLE && edge_seen |=> state == urwf_pkg::RX_START && slot == 5'h01;
  endproperty
  a_edge: assert property (p_edge) else $error("falling edge missed");

  property p_start_reject;
    rt_tick && receive_enable_bit && state == urwf_pkg::RX_START && cs == 5'd7 &&
      lows == 2'h0 && receive_line |=> state == urwf_pkg::RX_IDLE;
  endproperty
  a_start_reject: assert property (p_start_reject) else $error("noise taken as start");

  property p_resync;
    edge_seen && state != urwf_pkg::RX_IDLE |=> slot == 5'h01;
  endproperty
  a_resync: assert property (p_resync) else $error("no realign on edge");

  property p_refill;
    rt_tick && state == urwf_pkg::RX_STOP && cs == 5'd10 && !maj && rx_bits != 9'h000
      |=> hist == 3'h7;
  endproperty
  a_refill: assert property (p_refill) else $error("edge history not refilled");

  property p_fe_block;
    comp && framing_error_flag |=> $stable(serial_data_register) && !$rose(receive_full_flag);
  endproperty
  a_fe_block: assert property (p_fe_block) else $error("transfer while framing set");

  property p_sleep_quiet;
    comp && receiver_sleep_bit |=> !$rose(receive_full_flag) && !$rose(overrun_flag);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("flag set in sleep");

  property p_idle_wake;
    idle_hit && receiver_sleep_bit && !wake_addr && !sw_ctrl_two
      |=> !receiver_sleep_bit && !$rose(idle_flag);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wakeup failed");

  property p_mark_wake;
    mark_hit && !sw_ctrl_two |=> !receiver_sleep_bit ##[1:200] comp;
  endproperty
  a_mark_wake: assert property (p_mark_wake) else $error("address mark wakeup failed");

  property p_clear;
    data_rd && arm[4] && !take |=> !receive_full_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("receive-full not cleared");

  property p_no_err_on_overrun;
    lose |=> !$rose(noise_flag) && !$rose(framing_error_flag) && !$rose(parity_error_flag);
  endproperty
  a_no_err_on_overrun: assert property (p_no_err_on_overrun) else $error("error on overrun");

  c_take: cover property (take);
  c_overrun: cover property (lose);
  c_idle: cover property (set_idle);
  c_mark: cover property (mark_hit);
endmodule

// ### testbench/urwf_serial_source.sv
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: rt_tick is the receiver's 16x strobe; sixteen strobes per bit
// Notes: line idles high; a wrong stop bit or one noisy sample is sent only on request;
//   a wrong stop bit is low only through its deciding slots, so no false edge follows
`timescale 1ns/1ps

module urwf_serial_source (
  // clock and strobe
  input wire logic mclk,
  input wire logic rt_tick,
  // serial line
  output logic receive_line
);
  initial receive_line = 1'b1;

  // glitch flips one mid-bit sample of data bit 2; callers keep that bit low,
  // since a low spike on a high bit would be a falling edge and realign the slots
  task automatic send_frame(input logic [8:0] data, input logic nine, input logic stop_bit,
                            input logic glitch);
    logic [10:0] frame;
    int nbits;
    nbits = nine ? 11 : 10;
    frame = nine ? {stop_bit, data, 1'b0} : {1'b0, stop_bit, data[7:0], 1'b0};
    for (int i = 0; i <= nbits; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge mclk);
        for (int w = 0; w < 8 && rt_tick !== 1'b1; w++) @(posedge mclk);
        if (i == nbits) begin
          receive_line <= 1'b1;
          break;
        end
        if (t == 0) receive_line <= frame[i];
        else if (glitch && i == 3 && t == 8) receive_line <= ~frame[i];
        else if (glitch && i == 3 && t == 9) receive_line <= frame[i];
        else if (!stop_bit && i == nbits - 1 && t == 10) receive_line <= 1'b1;
      end
    end
  endtask
endmodule

// ### testbench/uart_receiver_wakeup_flags_tb.sv
// Purpose: self-checking bench for the serial receiver with wakeup and flags
// Assumes: rt_tick every fourth mclk; zero-wait slave
// Notes: reads note their expected word in a queue, a monitor compares in the data phase
`timescale 1ns/1ps
`include "urwf_params.svh"

module uart_receiver_wakeup_flags_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic receive_line;
  logic rt_tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic txe = 1'b1;
  logic txc = 1'b0;
  logic [7:0] tx_data;
  logic tx_write;
  logic tx_ninth;
  logic irq_tx, irq_rx, irq_err;
  logic rd_dp = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] tx_q[$];
  int err_total = 0;
  int n_checks = 0;
  int seed;
  logic [7:0] b;

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    rt_tick <= (tick_cnt == 2'h3);
  end

  urwf_core DUT (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .receive_line(receive_line), .rt_tick(rt_tick),
    .transmit_buffer_empty_flag(txe), .transmit_complete_flag(txc), .tx_data(tx_data),
    .tx_write(tx_write), .transmit_ninth_bit(tx_ninth), .irq_tx(irq_tx), .irq_rx(irq_rx),
    .irq_err(irq_err));

  urwf_serial_source src (.mclk(mclk), .rt_tick(rt_tick), .receive_line(receive_line));

  task automatic test_done;
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    wait_rdy();
    rd_dp <= 1'b0;
    hsel <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (a == `URWF_OFS_DATA) tx_q.push_back(d & 32'hFF);
    bus(a, 1'b1, d);
  endtask

  function automatic logic [31:0] st(input logic [7:0] f);
    return {24'h0, txe, txc, f[5:0]};
  endfunction

  task automatic irq(input logic [2:0] e);
    repeat (3) @(posedge mclk);
    cmp({29'h0, irq_tx, irq_rx, irq_err}, {29'h0, e});
  endtask

  // fixed waits in strobes: idle counts are defined in 16x strobes
  task automatic ticks(input int n);
    repeat (n * 4) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    if (rd_dp === 1'b1) begin
      cmp(hrdata, exp_q.pop_front());
      cmp({31'h0, hresp}, 32'h0);
    end
    if (tx_write === 1'b1) cmp({24'h0, tx_data}, tx_q.pop_front());
  end

  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    test_done();
  end

  initial begin
    seed = 32'he532ff47;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(`URWF_OFS_CTRL_ONE, 32'h0);
    rd(`URWF_OFS_CTRL_TWO, 32'h0);
    rd(`URWF_OFS_CTRL_THREE, 32'h0);
    rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    rd(8'h14, 32'h0);
    wr(`URWF_OFS_CTRL_TWO, 32'h24);
    wr(`URWF_OFS_CTRL_THREE, 32'h0F);
    for (int k = 0; k < 4; k++) begin
      b = $random(seed);
      src.send_frame({1'b0, b}, 1'b0, 1'b1, 1'b0);
      irq(3'h2);
      rd(`URWF_OFS_STATUS_ONE, st(8'h20));
      rd(`URWF_OFS_DATA, {24'h0, b});
      rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    end
    // overrun: second character lost with its framing fault
    b = $random(seed);
    src.send_frame({1'b0, b}, 1'b0, 1'b1, 1'b0);
    src.send_frame(9'h0A5, 1'b0, 1'b0, 1'b0);
    irq(3'h3);
    rd(`URWF_OFS_STATUS_ONE, st(8'h28));
    rd(`URWF_OFS_DATA, {24'h0, b});
    // one sample off inside a bit; bit 2 kept low so the spike makes no falling edge
    b = 8'($random(seed)) & 8'hFB;
    src.send_frame({1'b0, b}, 1'b0, 1'b1, 1'b1);
    rd(`URWF_OFS_STATUS_ONE, st(8'h24));
    rd(`URWF_OFS_DATA, {24'h0, b});
    // framing flag blocks the next character
    src.send_frame(9'h055, 1'b0, 1'b0, 1'b0);
    src.send_frame(9'h033, 1'b0, 1'b1, 1'b0);
    rd(`URWF_OFS_STATUS_ONE, st(8'h22));
    rd(`URWF_OFS_DATA, 32'h55);
    rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    // idle flag sets once, not again without a new character
    ticks(200);
    rd(`URWF_OFS_STATUS_ONE, st(8'h10));
    rd(`URWF_OFS_DATA, 32'h55);
    ticks(200);
    rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    // nine-bit character and ninth bits both ways
    wr(`URWF_OFS_CTRL_ONE, 32'h10);
    wr(`URWF_OFS_CTRL_THREE, 32'h4F);
    b = $random(seed);
    src.send_frame({1'b1, b}, 1'b1, 1'b1, 1'b0);
    rd(`URWF_OFS_STATUS_ONE, st(8'h20));
    rd(`URWF_OFS_CTRL_THREE, 32'hCF);
    rd(`URWF_OFS_DATA, {24'h0, b});
    cmp({31'h0, tx_ninth}, 32'h1);
    // parity on in nine-bit mode: a wrong ninth bit raises parity with receive-full
    wr(`URWF_OFS_CTRL_ONE, 32'h12);
    src.send_frame({~^b, b}, 1'b1, 1'b1, 1'b0);
    irq(3'h3);
    rd(`URWF_OFS_STATUS_ONE, st(8'h21));
    rd(`URWF_OFS_DATA, {24'h0, b});
    rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    wr(`URWF_OFS_DATA, {24'h0, ~b});
    // address-mark wakeup, eight-bit
    wr(`URWF_OFS_CTRL_ONE, 32'h08);
    wr(`URWF_OFS_CTRL_TWO, 32'h26);
    src.send_frame({1'b0, b & 8'h7F}, 1'b0, 1'b1, 1'b0);
    rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    rd(`URWF_OFS_CTRL_TWO, 32'h26);
    src.send_frame({1'b0, b | 8'h80}, 1'b0, 1'b1, 1'b0);
    rd(`URWF_OFS_CTRL_TWO, 32'h24);
    rd(`URWF_OFS_STATUS_ONE, st(8'h20));
    rd(`URWF_OFS_DATA, {24'h0, b | 8'h80});
    // idle-line wakeup: the waking idle sets no flag
    wr(`URWF_OFS_CTRL_ONE, 32'h00);
    wr(`URWF_OFS_CTRL_TWO, 32'h26);
    src.send_frame(9'h0C3, 1'b0, 1'b1, 1'b0);
    ticks(180);
    rd(`URWF_OFS_CTRL_TWO, 32'h24);
    rd(`URWF_OFS_STATUS_ONE, st(8'h00));
    // transmit request from either source, then masked
    wr(`URWF_OFS_CTRL_TWO, 32'hC4);
    for (int k = 0; k < 4; k++) begin
      {txe, txc} <= k[1:0];
      irq({k != 0, 2'h0});
    end
    wr(`URWF_OFS_CTRL_TWO, 32'h04);
    irq(3'h0);
    rd(`URWF_OFS_STATUS_ONE, 32'hC0);
    // let the monitor take the last data phase before the verdict
    repeat (2) @(posedge mclk);
    test_done();
  end
endmodule
